// ### src/iep_top.sv
// avalon-mm register block for interrupt enables and priorities
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
module iep_top (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [iep_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] bank3_request_i,
    input wire logic [15:0] bank5_request_i,
    output logic [15:0] bank3_enabled_o,
    output logic [15:0] bank5_enabled_o,
    output logic [15:0] bank3_priority_o,
    output logic [15:0] uart_ef_priority_o,
    output logic dma_ch5_irq_o,
    output logic [2:0] uart_f_tx_level_o
);
    typedef enum logic [1:0] {
        IEP_IDLE = 2'b00,
        IEP_ACK = 2'b01
    } iep_state_t;

    iep_state_t state_reg;
    logic [15:0] en3;
    logic [15:0] en5;
    logic [15:0] pr3;
    logic [15:0] pr_uart;
    logic [3:0] wr_sel;
    logic word_write;
    logic [15:0] rd_next;

    function automatic logic [15:0] pick(
        input logic [iep_pkg::ADDR_W-1:0] a,
        input logic [15:0] e3, e5, p3, pu);
        case (a)
            iep_pkg::OFS_ENABLE_BANK_THREE: pick = e3;
            iep_pkg::OFS_ENABLE_BANK_FIVE: pick = e5;
            iep_pkg::OFS_PRIORITY_BANK_THREE: pick = p3;
            iep_pkg::OFS_PRIORITY_UART_EF: pick = pu;
            default: pick = iep_pkg::READ_NOT_MAPPED;
        endcase
    endfunction : pick

    // writes only take effect when both low byte lanes are enabled
    assign word_write = avs_write_i && (state_reg == IEP_IDLE)
        && (avs_byteenable_i[1:0] == 2'b11);
    assign wr_sel[0] = word_write
        && avs_address_i == iep_pkg::OFS_ENABLE_BANK_THREE;
    assign wr_sel[1] = word_write
        && avs_address_i == iep_pkg::OFS_ENABLE_BANK_FIVE;
    assign wr_sel[2] = word_write
        && avs_address_i == iep_pkg::OFS_PRIORITY_BANK_THREE;
    assign wr_sel[3] = word_write
        && avs_address_i == iep_pkg::OFS_PRIORITY_UART_EF;
    assign rd_next = pick(avs_address_i, en3, en5, pr3, pr_uart);

    iep_reg16 #(.MASK(iep_pkg::MASK_ENABLE_BANK_THREE),
        .RESET_VALUE(iep_pkg::RST_ENABLE)) u_en3 (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .write_i(wr_sel[0]),
        .wdata_i(avs_writedata_i[15:0]), .value_o(en3));
    iep_reg16 #(.MASK(iep_pkg::MASK_ENABLE_BANK_FIVE),
        .RESET_VALUE(iep_pkg::RST_ENABLE)) u_en5 (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .write_i(wr_sel[1]),
        .wdata_i(avs_writedata_i[15:0]), .value_o(en5));
    iep_reg16 #(.MASK(iep_pkg::MASK_PRIORITY),
        .RESET_VALUE(iep_pkg::RST_PRIORITY)) u_pr3 (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .write_i(wr_sel[2]),
        .wdata_i(avs_writedata_i[15:0]), .value_o(pr3));
    iep_reg16 #(.MASK(iep_pkg::MASK_PRIORITY),
        .RESET_VALUE(iep_pkg::RST_PRIORITY)) u_pru (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .write_i(wr_sel[3]),
        .wdata_i(avs_writedata_i[15:0]), .value_o(pr_uart));

    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= IEP_IDLE;
        end else begin
            case (state_reg)
                IEP_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        state_reg <= IEP_ACK;
                    end
                end
                IEP_ACK: state_reg <= IEP_IDLE;
                default: state_reg <= IEP_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((state_reg == IEP_IDLE)
                && (avs_read_i || avs_write_i));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && state_reg == IEP_IDLE) begin
            avs_readdata_o <= {16'h0000, rd_next};
        end
    end

    // gated requests and register images
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            bank3_enabled_o <= 16'h0000;
            bank5_enabled_o <= 16'h0000;
            bank3_priority_o <= iep_pkg::RST_PRIORITY;
            uart_ef_priority_o <= iep_pkg::RST_PRIORITY;
        end else begin
            bank3_enabled_o <= bank3_request_i & en3;
            bank5_enabled_o <= bank5_request_i & en5;
            bank3_priority_o <= pr3;
            uart_ef_priority_o <= pr_uart;
        end
    end

    iep_gate u_dma5 (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .request_i(bank3_request_i[iep_pkg::BIT_DMA_CH5_IRQ_ENABLE]),
        .enable_i(en3[iep_pkg::BIT_DMA_CH5_IRQ_ENABLE]),
        .priority_i(pr_uart[14:12]),
        .pending_o(dma_ch5_irq_o), .level_o());
    iep_gate u_uf_tx (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .request_i(bank5_request_i[iep_pkg::BIT_UART_C_TX_IRQ_ENABLE]),
        .enable_i(en5[iep_pkg::BIT_UART_C_TX_IRQ_ENABLE]),
        .priority_i(pr_uart[14:12]),
        .pending_o(), .level_o(uart_f_tx_level_o));
endmodule : iep_top
`default_nettype wire

// ### src/iep_pkg.sv
// constants and register map for the interrupt enable and priority block
// Notes on behaviour
// - enable bit 1 passes its source request (to dma_ch5_irq_o only at nonzero priority), 0 blocks it
// - unimplemented bits ignore writes and read back as zero
// - each priority field resets to binary 100, level four
// - enable bank three bit 13 is DMA channel 5 enable, reset clear
// - enable bank five: uart c tx bit 3, rx bit 2, error bit 1
`default_nettype none
package iep_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 4;
    // byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_ENABLE_BANK_THREE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_BANK_FIVE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_BANK_THREE = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_UART_EF = 4'hc;
    // implemented bit masks
    localparam logic [REG_W-1:0] MASK_ENABLE_BANK_THREE = 16'hffe0;
    localparam logic [REG_W-1:0] MASK_ENABLE_BANK_FIVE = 16'h000e;
    localparam logic [REG_W-1:0] MASK_PRIORITY = 16'h7777;
    // reset values
    localparam logic [REG_W-1:0] RST_ENABLE = 16'h0000;
    localparam logic [REG_W-1:0] RST_PRIORITY = 16'h4444;
    // field positions
    localparam int BIT_DMA_CH5_IRQ_ENABLE = 13;
    localparam int BIT_UART_C_TX_IRQ_ENABLE = 3;
    localparam int BIT_UART_C_RX_IRQ_ENABLE = 2;
    localparam int BIT_UART_C_ERR_IRQ_ENABLE = 1;
    localparam int PRIO_FIELD_W = 3;
    localparam int PRIO_FIELDS = 4;
    localparam int PRIO_STRIDE = 4;
    localparam logic [REG_W-1:0] READ_NOT_MAPPED = 16'h0000;
endpackage : iep_pkg
`default_nettype wire

// ### src/iep_reg16.sv
// one 16-bit software register with a write mask and reset value
`default_nettype none
module iep_reg16 #(
    parameter logic [15:0] MASK = 16'hffff,
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic write_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] value_o
);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            value_o <= RESET_VALUE & MASK;
        end else if (write_i) begin
            value_o <= wdata_i & MASK;
        end
    end
endmodule : iep_reg16
`default_nettype wire

// ### src/iep_gate.sv
// gates source requests by enable and attaches priority level
`default_nettype none
module iep_gate (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic request_i,
    input wire logic enable_i,
    input wire logic [2:0] priority_i,
    output logic pending_o,
    output logic [2:0] level_o
);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pending_o <= 1'b0;
            level_o <= 3'h0;
        end else begin
            pending_o <= request_i & enable_i & (priority_i != 3'h0);
            level_o <= (request_i & enable_i) ? priority_i : 3'h0;
        end
    end
endmodule : iep_gate
`default_nettype wire

// ### dv/iep_properties.sv
// port checker for the interrupt enable and priority block
`default_nettype none
module iep_chk (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [15:0] bank3_request_i,
    input wire logic [15:0] bank3_enabled_o,
    input wire logic [15:0] bank5_enabled_o,
    input wire logic [15:0] bank3_priority_o,
    input wire logic [15:0] uart_ef_priority_o,
    input wire logic dma_ch5_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence req_waiting;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence answer_given;
        ##[1:4] !avs_waitrequest_o;
    endsequence
    AST_RESET_VALUES: assert property (
        $fell(reset_i) |-> bank3_priority_o == 16'h4444 &&
        uart_ef_priority_o == 16'h4444 && bank3_enabled_o == 16'h0000)
        else $error("reset values wrong");
    AST_PRIO_GAPS: assert property (
        (bank3_priority_o & 16'h8888) == 16'h0000)
        else $error("priority gap bit set");
    AST_UART_PRIO_GAPS: assert property (
        (uart_ef_priority_o & 16'h8888) == 16'h0000)
        else $error("uart priority gap bit set");
    AST_ENABLE_GAPS: assert property (
        (bank3_enabled_o & 16'h001f) == 16'h0000 &&
        (bank5_enabled_o & 16'hfff1) == 16'h0000)
        else $error("unimplemented enable bit set");
    AST_GATE: assert property (
        (bank3_enabled_o & ~$past(bank3_request_i)) == 16'h0000)
        else $error("enabled output without request");
    AST_READ_HIGH: assert property (
        avs_readdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_WAIT_PULSE: assert property (
        $fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_ANSWER: assert property (
        req_waiting |-> answer_given)
        else $error("request not answered");
    AST_DMA_CAUSE: assert property (
        dma_ch5_irq_o |-> $past(bank3_request_i[13]))
        else $error("dma channel 5 irq without request");
endmodule : iep_chk
bind iep_top iep_chk i_iep_chk (.sys_clk_i, .reset_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .bank3_request_i,
    .bank3_enabled_o, .bank5_enabled_o, .bank3_priority_o,
    .uart_ef_priority_o, .dma_ch5_irq_o);
`default_nettype wire

// ### dv/iep_top_bench.sv
// self-checking bench for the interrupt enable and priority block
`default_nettype none
module iep_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, rdata;
    logic avs_waitrequest_o, dma_ch5_irq_o;
    logic [15:0] bank3_request_i = 16'h0;
    logic [15:0] bank5_request_i = 16'h0;
    logic [15:0] bank3_enabled_o, bank5_enabled_o, bank3_priority_o;
    logic [15:0] uart_ef_priority_o;
    logic [2:0] uart_f_tx_level_o;
    logic [3:0] ofs [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
    logic [15:0] rstv [4] = '{16'h0, 16'h0, 16'h4444, 16'h4444};
    logic [15:0] msk [4] = '{16'hffe0, 16'h000e, 16'h7777, 16'h7777};
    int n_errors = 0;
    int check_count = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    iep_top i_iep_top (.sys_clk_i, .reset_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .bank3_request_i, .bank5_request_i,
        .bank3_enabled_o, .bank5_enabled_o, .bank3_priority_o,
        .uart_ef_priority_o, .dma_ch5_irq_o, .uart_f_tx_level_o);
    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic access(input logic wr, input logic [3:0] a,
        input logic [15:0] d);
        avs_address_i <= a;
        avs_writedata_i <= {16'h0000, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : access
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        access(1'b0, a, 16'h0000);
        check("readdata", rdata, {16'h0000, e});
    endtask : rd
    task automatic pins(input logic [15:0] e3, e5, input logic d,
        input logic [2:0] lv);
        repeat (2) @(posedge sys_clk_i);
        check("bank3", {16'h0000, bank3_enabled_o}, {16'h0000, e3});
        check("bank5", {16'h0000, bank5_enabled_o}, {16'h0000, e5});
        check("dma5", {31'h0, dma_ch5_irq_o}, {31'h0, d});
        check("level", {29'h0, uart_f_tx_level_o}, {29'h0, lv});
    endtask : pins
    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    initial begin
        #50000;
        n_errors++;
        results();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rstv[i]);
        foreach (ofs[i]) access(1'b1, ofs[i], 16'hffff);
        foreach (ofs[i]) rd(ofs[i], msk[i]);
        access(1'b1, 4'h2, 16'hffff);
        rd(4'h2, 16'h0000);
        avs_byteenable_i <= 4'h1;
        access(1'b1, 4'h0, 16'h0000);
        avs_byteenable_i <= 4'hf;
        rd(4'h0, 16'hffe0);
        bank3_request_i <= 16'hffff;
        bank5_request_i <= 16'hffff;
        pins(16'hffe0, 16'h000e, 1'b1, 3'h7);
        access(1'b1, 4'hc, 16'h3777);
        pins(16'hffe0, 16'h000e, 1'b1, 3'h3);
        access(1'b1, 4'hc, 16'h0777);
        pins(16'hffe0, 16'h000e, 1'b0, 3'h0);
        check("prio_ef", {16'h0, uart_ef_priority_o}, 32'h0777);
        check("prio_b3", {16'h0, bank3_priority_o}, 32'h7777);
        access(1'b1, 4'h0, 16'hdfe0);
        access(1'b1, 4'h4, 16'h0004);
        pins(16'hdfe0, 16'h0004, 1'b0, 3'h0);
        // second reset in mid-run must restore every register
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rstv[i]);
        pins(16'h0000, 16'h0000, 1'b0, 3'h0);
        results();
    end
endmodule : iep_top_bench
`default_nettype wire
